// file: hdl/sfrb_pkg.sv
package sfrb_pkg;

    typedef logic [7:0] sfrb_byte_t;
    typedef logic [4:0] sfrb_slot_t;

    // Register indices (byte address on the bus is four times these)
    localparam logic [7:0] OFS_PLO    = 8'h82;
    localparam logic [7:0] OFS_PHI    = 8'h83;
    localparam logic [7:0] OFS_CDIV   = 8'h95;
    localparam logic [7:0] OFS_ADC1   = 8'h97;
    localparam logic [7:0] OFS_MODB   = 8'ha1;
    localparam logic [7:0] OFS_AUX    = 8'ha2;
    localparam logic [7:0] OFS_INSEL  = 8'ha3;
    localparam logic [7:0] OFS_INTE   = 8'ha8;
    localparam logic [7:0] OFS_CMP    = 8'hac;
    localparam logic [7:0] OFS_BNDL   = 8'hbc;
    localparam logic [7:0] OFS_MODA   = 8'hc0;
    localparam logic [7:0] OFS_BNDH   = 8'hc4;
    localparam logic [7:0] OFS_RES0   = 8'hd5;
    localparam logic [7:0] OFS_RES1   = 8'hd6;
    localparam logic [7:0] OFS_RES2   = 8'hd7;
    localparam logic [7:0] OFS_ACU    = 8'he0;
    localparam logic [7:0] OFS_FMCTL  = 8'he4;
    localparam logic [7:0] OFS_FMDAT  = 8'he5;
    localparam logic [7:0] OFS_FMADL  = 8'he6;
    localparam logic [7:0] OFS_FMADH  = 8'he7;
    localparam logic [7:0] OFS_BREG   = 8'hf0;
    localparam logic [7:0] OFS_RES3   = 8'hf5;

    // Storage slots inside the register file
    localparam int         NUM_SLOTS  = 21;
    localparam sfrb_slot_t SLOT_NONE  = 5'h1f;
    localparam sfrb_slot_t SLOT_PLO   = 5'h00;
    localparam sfrb_slot_t SLOT_PHI   = 5'h01;
    localparam sfrb_slot_t SLOT_CDIV  = 5'h02;
    localparam sfrb_slot_t SLOT_ADC1  = 5'h03;
    localparam sfrb_slot_t SLOT_MODB  = 5'h04;
    localparam sfrb_slot_t SLOT_AUX   = 5'h05;
    localparam sfrb_slot_t SLOT_INSEL = 5'h06;
    localparam sfrb_slot_t SLOT_INTE  = 5'h07;
    localparam sfrb_slot_t SLOT_CMP   = 5'h08;
    localparam sfrb_slot_t SLOT_BNDL  = 5'h09;
    localparam sfrb_slot_t SLOT_MODA  = 5'h0a;
    localparam sfrb_slot_t SLOT_BNDH  = 5'h0b;
    localparam sfrb_slot_t SLOT_RES0  = 5'h0c;
    localparam sfrb_slot_t SLOT_RES1  = 5'h0d;
    localparam sfrb_slot_t SLOT_RES2  = 5'h0e;
    localparam sfrb_slot_t SLOT_ACU   = 5'h0f;
    localparam sfrb_slot_t SLOT_FMDAT = 5'h10;
    localparam sfrb_slot_t SLOT_FMADL = 5'h11;
    localparam sfrb_slot_t SLOT_FMADH = 5'h12;
    localparam sfrb_slot_t SLOT_BREG  = 5'h13;
    localparam sfrb_slot_t SLOT_RES3  = 5'h14;

    // Reset values and field layout
    localparam sfrb_byte_t RST_ZERO     = 8'h00;
    localparam sfrb_byte_t RST_BNDH     = 8'hff;
    localparam sfrb_byte_t FM_RST_READ  = 8'h70;
    localparam sfrb_byte_t FM_FIXED_ONE = 8'h70;
    localparam int         FM_BUSY_BIT  = 7;
    localparam int         AUX_SOFT_BIT = 3;
    localparam int         AUX_ZERO_BIT = 2;
    // Bits that hold state; all others read zero
    localparam sfrb_byte_t MASK_ALL   = 8'hff;
    localparam sfrb_byte_t MASK_ADC1  = 8'hef;
    localparam sfrb_byte_t MASK_HINIB = 8'hf0;
    localparam sfrb_byte_t MASK_MODB  = 8'hea;
    localparam sfrb_byte_t MASK_AUX   = 8'hf1;
    localparam sfrb_byte_t MASK_CMP   = 8'h3b;
    localparam sfrb_byte_t MASK_INTE  = 8'hea;
    // Bus index layout: bit 8 selects the bit-address window
    localparam int         IDX_W      = 9;
    localparam int         IDX_BITWIN = 8;

    function automatic sfrb_slot_t slot_of(input sfrb_byte_t ofs);
        case (ofs)
            OFS_PLO:   slot_of = SLOT_PLO;
            OFS_PHI:   slot_of = SLOT_PHI;
            OFS_CDIV:  slot_of = SLOT_CDIV;
            OFS_ADC1:  slot_of = SLOT_ADC1;
            OFS_MODB:  slot_of = SLOT_MODB;
            OFS_AUX:   slot_of = SLOT_AUX;
            OFS_INSEL: slot_of = SLOT_INSEL;
            OFS_INTE:  slot_of = SLOT_INTE;
            OFS_CMP:   slot_of = SLOT_CMP;
            OFS_BNDL:  slot_of = SLOT_BNDL;
            OFS_MODA:  slot_of = SLOT_MODA;
            OFS_BNDH:  slot_of = SLOT_BNDH;
            OFS_RES0:  slot_of = SLOT_RES0;
            OFS_RES1:  slot_of = SLOT_RES1;
            OFS_RES2:  slot_of = SLOT_RES2;
            OFS_ACU:   slot_of = SLOT_ACU;
            OFS_FMDAT: slot_of = SLOT_FMDAT;
            OFS_FMADL: slot_of = SLOT_FMADL;
            OFS_FMADH: slot_of = SLOT_FMADH;
            OFS_BREG:  slot_of = SLOT_BREG;
            OFS_RES3:  slot_of = SLOT_RES3;
            default:   slot_of = SLOT_NONE;
        endcase
    endfunction

    function automatic sfrb_byte_t mask_of(input sfrb_slot_t s);
        case (s)
            SLOT_ADC1:              mask_of = MASK_ADC1;
            SLOT_INSEL, SLOT_MODA:  mask_of = MASK_HINIB;
            SLOT_MODB:              mask_of = MASK_MODB;
            SLOT_AUX:               mask_of = MASK_AUX;
            SLOT_CMP:               mask_of = MASK_CMP;
            SLOT_INTE:              mask_of = MASK_INTE;
            default:                mask_of = MASK_ALL;
        endcase
    endfunction

    function automatic sfrb_byte_t reset_of(input sfrb_slot_t s);
        reset_of = (s == SLOT_BNDH) ? RST_BNDH : RST_ZERO;
    endfunction

endpackage

// file: hdl/sfrb_wb_front.sv
`timescale 1ns/10ps
module sfrb_wb_front (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Wishbone handshake
    input  wire logic cyc_i,
    input  wire logic stb_i,
    output logic      ack_o,
    // One-cycle access strobe toward the bank
    output logic      req_o
);

    logic ack_ff;

    // Masking the request while ack is high keeps one held request from acting twice
    assign req_o = cyc_i & stb_i & ~ack_ff;
    assign ack_o = ack_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req_o;
        end
    end

endmodule

// file: hdl/sfrb_regfile.sv
`timescale 1ns/10ps
module sfrb_regfile
    import sfrb_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Write port
    input  wire logic              we_i,
    input  wire sfrb_pkg::sfrb_slot_t slot_i,
    input  wire sfrb_pkg::sfrb_byte_t wdata_i,
    // Every stored byte, straight from its flip-flops
    output sfrb_pkg::sfrb_byte_t   q_o [sfrb_pkg::NUM_SLOTS]
);

    sfrb_byte_t mem_ff [NUM_SLOTS];

    always_ff @(posedge clk_i) begin
        for (int i = 0; i < NUM_SLOTS; i++) begin
            if (rst_i) begin
                mem_ff[i] <= reset_of(sfrb_slot_t'(i));
            end else if (we_i && slot_i == sfrb_slot_t'(i)) begin
                mem_ff[i] <= wdata_i & mask_of(slot_i);
            end
        end
    end

    assign q_o = mem_ff;

endmodule

// file: hdl/sfrb_bank.sv
// The Wishbone register port is this design's own decision.
`timescale 1ns/10ps
// Contract
// - Reserved bits written zero, read unspecified
// - Fixed-zero bits always read back zero
// - Fixed-one bits always read back one
// - Flash control reads status, writes command
// - Flash status resets 70h, flash data/address zero
// - Accumulator and B allow single-bit access
// - Boundary high resets ones, low zeros
// - Four converter result registers reset zero
// - Data pointer is high and low byte
// - Flash address high/low bytes reset zero
module sfrb_bank
    import sfrb_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Flash controller status
    input  wire logic        flash_busy_i,
    input  wire logic [3:0]  flash_flags_i,
    // Flash controller command side
    output logic [7:0]       flash_command_byte_o,
    output logic             flash_command_stb_o,
    output logic [7:0]       flash_write_data_o,
    output logic [15:0]      flash_address_o,
    // Core and peripheral controls
    output logic [15:0]      data_pointer_word_o,
    output logic [7:0]       accumulator_o,
    output logic [7:0]       multiply_aux_operand_o,
    output logic [7:0]       cpu_clock_divider_o,
    output logic [7:0]       auxiliary_function_o,
    output logic             software_reset_o,
    output logic [7:0]       interrupt_enable_zero_o,
    output logic [7:0]       comparator_one_control_o,
    // Converter controls
    output logic [7:0]       converter_control_one_o,
    output logic [7:0]       converter_mode_a_o,
    output logic [7:0]       converter_mode_b_o,
    output logic [7:0]       converter_input_select_o,
    output logic [7:0]       converter_boundary_high_o,
    output logic [7:0]       converter_boundary_low_o
);

    ////////////////////////////////////////////////////////////////////////
    // Decode

    logic [IDX_W-1:0] idx;
    sfrb_byte_t       ofs;
    logic             bit_win;
    logic [2:0]       bit_pos;
    sfrb_slot_t       byte_slot;
    sfrb_slot_t       bit_slot;
    logic             is_fmctl;
    logic             req;
    logic             wr_en;
    sfrb_byte_t       q [NUM_SLOTS];

    assign idx     = wb_adr_i[IDX_W+1:2];
    assign ofs     = idx[7:0];
    assign bit_win = idx[IDX_BITWIN];
    assign bit_pos = ofs[2:0];
    assign byte_slot = slot_of(ofs);
    assign is_fmctl  = !bit_win && ofs == OFS_FMCTL;
    assign wr_en     = req && wb_we_i && wb_sel_i[0];

    always_comb begin
        case ({ofs[7:3], 3'h0})
            OFS_ACU:  bit_slot = SLOT_ACU;
            OFS_BREG: bit_slot = SLOT_BREG;
            OFS_INTE: bit_slot = SLOT_INTE;
            default:  bit_slot = SLOT_NONE;
        endcase
    end

    sfrb_wb_front u_front (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .cyc_i (wb_cyc_i),
        .stb_i (wb_stb_i),
        .ack_o (wb_ack_o),
        .req_o (req)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register file write path

    logic       rf_we;
    sfrb_slot_t rf_slot;
    sfrb_byte_t rf_wdata;
    sfrb_byte_t bit_sel;

    assign bit_sel = 8'h01 << bit_pos;

    always_comb begin
        rf_we    = 1'b0;
        rf_slot  = SLOT_NONE;
        rf_wdata = 8'h00;
        if (wr_en && bit_win && bit_slot != SLOT_NONE) begin
            rf_we    = 1'b1;
            rf_slot  = bit_slot;
            rf_wdata = (q[bit_slot] & ~bit_sel)
                     | (wb_dat_i[0] ? bit_sel : 8'h00);
        end else if (wr_en && !bit_win && byte_slot != SLOT_NONE) begin
            rf_we    = 1'b1;
            rf_slot  = byte_slot;
            rf_wdata = wb_dat_i[7:0];
        end
    end

    sfrb_regfile u_regs (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .we_i    (rf_we),
        .slot_i  (rf_slot),
        .wdata_i (rf_wdata),
        .q_o     (q)
    );

    ////////////////////////////////////////////////////////////////////////
    // Flash control: status on read, command on write

    logic       fm_busy_ff;
    logic [3:0] fm_flags_ff;
    sfrb_byte_t fm_cmd_ff;
    logic       fm_stb_ff;
    sfrb_byte_t fm_status;

    // status zeroed so the read shows 70h
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fm_busy_ff  <= 1'b0;
            fm_flags_ff <= 4'h0;
        end else begin
            fm_busy_ff  <= flash_busy_i;
            fm_flags_ff <= flash_flags_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fm_cmd_ff <= 8'h00;
            fm_stb_ff <= 1'b0;
        end else begin
            fm_stb_ff <= wr_en && is_fmctl;
            if (wr_en && is_fmctl) begin
                fm_cmd_ff <= wb_dat_i[7:0];
            end
        end
    end

    // fixed-one field of the status byte
    assign fm_status = FM_FIXED_ONE | {fm_busy_ff, 3'h0, fm_flags_ff};

    ////////////////////////////////////////////////////////////////////////
    // Software reset request

    logic soft_rst_ff;

    // bit 3 of the auxiliary register pulses, never stored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            soft_rst_ff <= 1'b0;
        end else begin
            soft_rst_ff <= wr_en && !bit_win && byte_slot == SLOT_AUX
                           && wb_dat_i[AUX_SOFT_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path

    sfrb_byte_t nxt_dat;
    sfrb_byte_t dat_ff;

    // reserved and fixed-zero bits are never stored, so read zero
    always_comb begin
        nxt_dat = 8'h00;
        if (bit_win) begin
            if (bit_slot != SLOT_NONE) begin
                nxt_dat = {7'h00, q[bit_slot][bit_pos]};
            end
        end else if (is_fmctl) begin
            nxt_dat = fm_status;
        end else if (byte_slot != SLOT_NONE) begin
            nxt_dat = q[byte_slot];
        end
    end

    // Unmapped reads answer zero; the ack itself is never withheld
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_ff <= 8'h00;
        end else if (req && !wb_we_i) begin
            dat_ff <= nxt_dat;
        end
    end

    assign wb_dat_o = {24'h000000, dat_ff};

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from register-file or local flip-flops

    assign flash_command_byte_o      = fm_cmd_ff;
    assign flash_command_stb_o       = fm_stb_ff;
    assign flash_write_data_o        = q[SLOT_FMDAT];
    assign flash_address_o           = {q[SLOT_FMADH], q[SLOT_FMADL]};
    assign data_pointer_word_o       = {q[SLOT_PHI], q[SLOT_PLO]};
    assign accumulator_o             = q[SLOT_ACU];
    assign multiply_aux_operand_o    = q[SLOT_BREG];
    assign cpu_clock_divider_o       = q[SLOT_CDIV];
    assign auxiliary_function_o      = q[SLOT_AUX];
    assign software_reset_o          = soft_rst_ff;
    assign interrupt_enable_zero_o   = q[SLOT_INTE];
    assign comparator_one_control_o  = q[SLOT_CMP];
    assign converter_control_one_o   = q[SLOT_ADC1];
    assign converter_mode_a_o        = q[SLOT_MODA];
    assign converter_mode_b_o        = q[SLOT_MODB];
    assign converter_input_select_o  = q[SLOT_INSEL];
    assign converter_boundary_high_o = q[SLOT_BNDH];
    assign converter_boundary_low_o  = q[SLOT_BNDL];

    ////////////////////////////////////////////////////////////////////////
    // Checks

    logic [IDX_W-1:0] last_idx_ff;
    logic             last_rd_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_idx_ff <= '0;
            last_rd_ff  <= 1'b0;
        end else if (req) begin
            last_idx_ff <= idx;
            last_rd_ff  <= !wb_we_i;
        end
    end

    AST_RSVD_READ_ZERO: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o && last_rd_ff && last_idx_ff == {1'b0, OFS_INSEL}
        |-> wb_dat_o[3:0] == 4'h0)
        else $error("Reserved input-select bits read nonzero");

    AST_AUX_BIT2_ZERO: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o && last_rd_ff && last_idx_ff == {1'b0, OFS_AUX}
        |-> !wb_dat_o[AUX_ZERO_BIT] && !wb_dat_o[AUX_SOFT_BIT])
        else $error("Auxiliary fixed-zero bit read as one");

    AST_FM_FIXED_ONES: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o && last_rd_ff && last_idx_ff == {1'b0, OFS_FMCTL}
        |-> wb_dat_o[6:4] == 3'h7
            && wb_dat_o[FM_BUSY_BIT] == $past(fm_busy_ff))
        else $error("Flash status fixed bits or busy wrong");

    AST_FM_CMD_WRITE: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wr_en && is_fmctl
        |=> flash_command_stb_o
            && flash_command_byte_o == $past(wb_dat_i[7:0])
            ##1 !flash_command_stb_o)
        else $error("Flash command not captured as one pulse");

    AST_FM_RESET: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $past(rst_i) |-> fm_status == FM_RST_READ
            && flash_write_data_o == 8'h00 && flash_address_o == 16'h0000)
        else $error("Flash registers not at reset value");

    AST_BIT_WRITE: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wr_en && bit_win && bit_slot == SLOT_ACU
        |=> accumulator_o[$past(bit_pos)] == $past(wb_dat_i[0])
            && (accumulator_o & ~$past(bit_sel))
               == ($past(accumulator_o) & ~$past(bit_sel)))
        else $error("Accumulator bit write disturbed other bits");

    AST_BOUNDARY_RESET: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $past(rst_i) |-> converter_boundary_high_o == 8'hff
            && converter_boundary_low_o == 8'h00)
        else $error("Boundary registers not at reset value");

    AST_RESULT_RESET: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $past(rst_i) |-> q[SLOT_RES0] == 8'h00 && q[SLOT_RES1] == 8'h00
            && q[SLOT_RES2] == 8'h00 && q[SLOT_RES3] == 8'h00)
        else $error("Converter result registers not cleared");

    AST_PTR_HIGH: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wr_en && !bit_win && byte_slot == SLOT_PHI
        |=> data_pointer_word_o
            == {$past(wb_dat_i[7:0]), $past(data_pointer_word_o[7:0])})
        else $error("Data pointer high byte not updated alone");

    AST_FM_ADDR_LOW: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wr_en && !bit_win && byte_slot == SLOT_FMADL
        |=> flash_address_o
            == {$past(flash_address_o[15:8]), $past(wb_dat_i[7:0])})
        else $error("Flash address low byte not updated alone");

    AST_SOFT_RST_PULSE: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wr_en && !bit_win && byte_slot == SLOT_AUX
        |=> software_reset_o == $past(wb_dat_i[AUX_SOFT_BIT])
            && auxiliary_function_o[3:1] == 3'h0)
        else $error("Software reset pulse or aux fixed bits wrong");

    AST_NO_STRAY_WRITE: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !(wr_en && (bit_win ? bit_slot == SLOT_ACU
                            : byte_slot == SLOT_ACU))
        |=> $stable(accumulator_o))
        else $error("Accumulator changed without a write");

endmodule

// file: tb/sfrb_core_model.sv
`timescale 1ns/10ps
module sfrb_core_model (
    // Clock
    input  wire logic        clk_i,
    // Wishbone master side
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic [11:0]      adr_o,
    output logic [3:0]       sel_o,
    output logic [31:0]      dat_o,
    input  wire logic [31:0] dat_i,
    input  wire logic        ack_i
);
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o  = 1'b0;
        adr_o = 12'h000;
        sel_o = 4'h0;
        dat_o = 32'h00000000;
    end

    ////////////////////////////////////////////////////////////
    // One classic cycle; no limit on the wait, the bench watchdog
    // is what ends a hung bus
    task automatic xfer(input logic w, input logic [8:0] idx,
                        input logic [3:0] sel, input logic [7:0] d,
                        output logic [7:0] q);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= w;
        adr_o <= {1'b0, idx, 2'b00};
        sel_o <= sel;
        dat_o <= {24'h000000, d};
        do begin
            @(posedge clk_i);
        end while (ack_i !== 1'b1);
        q = dat_i[7:0];
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        // Released data lines flip so a stale byte is never read as valid
        dat_o <= ~dat_o;
    endtask
endmodule

// file: tb/tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) \
    begin \
        checks++; \
        if ((g) !== (e)) begin \
            mismatches++; \
            $display("CHECK FAILED %s exp %h got %h", nm, (e), (g)); \
        end \
    end
module tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        busy = 1'b0;
    logic [3:0]  flags = 4'h0;
    logic        cyc, stb, we, ack, cstb, swrst;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat;
    logic [7:0]  cmd, fwd, accu, bq, aux, ien, bndh, bndl, q, d, e;
    logic [7:0]  cdiv, cmpc, cc1, mda, mdb, ins;
    logic [15:0] fadr, data_pointer_word;
    logic [7:0]  mir [21];
    int          mismatches = 0;
    int          checks = 0;
    int          seed = 48977;
    int          stb_cnt = 0;
    int          swrst_cnt = 0;
    // only mapped addresses are ever driven
    localparam logic [7:0] IDX [21] = '{8'h82, 8'h83, 8'h95, 8'h97, 8'ha1,
        8'ha2, 8'ha3, 8'ha8, 8'hac, 8'hbc, 8'hc0, 8'hc4, 8'hd5, 8'hd6,
        8'hd7, 8'he0, 8'he5, 8'he6, 8'he7, 8'hf0, 8'hf5};
    localparam logic [7:0] MSK [21] = '{8'hff, 8'hff, 8'hff, 8'hef, 8'hea,
        8'hf1, 8'hf0, 8'hea, 8'h3b, 8'hff, 8'hf0, 8'hff, 8'hff, 8'hff,
        8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};

    initial begin
        forever #2.5 clk = ~clk;
    end

    sfrb_core_model sfrb_core_model_inst (
        .clk_i(clk), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
        .sel_o(sel), .dat_o(wdat), .dat_i(rdat), .ack_i(ack)
    );
    sfrb_bank sfrb_bank_inst (
        .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .flash_busy_i(busy),
        .flash_flags_i(flags), .flash_command_byte_o(cmd),
        .flash_command_stb_o(cstb), .flash_write_data_o(fwd),
        .flash_address_o(fadr), .data_pointer_word_o(data_pointer_word),
        .accumulator_o(accu), .multiply_aux_operand_o(bq),
        .cpu_clock_divider_o(cdiv), .auxiliary_function_o(aux),
        .software_reset_o(swrst), .interrupt_enable_zero_o(ien),
        .comparator_one_control_o(cmpc), .converter_control_one_o(cc1),
        .converter_mode_a_o(mda), .converter_mode_b_o(mdb),
        .converter_input_select_o(ins), .converter_boundary_high_o(bndh),
        .converter_boundary_low_o(bndl)
    );

    // Pulses are counted, not sampled after a task, to avoid edge races
    always @(posedge clk) begin
        if (cstb === 1'b1) stb_cnt++;
        if (swrst === 1'b1) swrst_cnt++;
    end

    ////////////////////////////////////////////////////////////
    task automatic wr(input logic [8:0] i, input logic [7:0] v);
        logic [7:0] x;
        sfrb_core_model_inst.xfer(1'b1, i, 4'h1, v, x);
    endtask

    task automatic rd(input logic [8:0] i, output logic [7:0] x);
        sfrb_core_model_inst.xfer(1'b0, i, 4'hf, 8'h00, x);
    endtask

    task automatic chk_reset();
        for (int k = 0; k < 21; k++) begin
            rd({1'b0, IDX[k]}, q);
            `CHK("reset", (IDX[k] == 8'hc4) ? 8'hff : 8'h00, q)
        end
        rd(9'h0e4, q);
        `CHK("flash status reset", 8'h70, q)
        `CHK("boundary high port", 8'hff, bndh)
        `CHK("pointer port", 16'h0000, data_pointer_word)
        `CHK("flash address port", 16'h0000, fadr)
        $display("test reset values done");
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        chk_reset();
        for (int n = 0; n < 3; n++) begin
            // reserved and fixed-zero bits written zero
            for (int k = 0; k < 21; k++) begin
                mir[k] = 8'($random(seed)) & MSK[k];
                wr({1'b0, IDX[k]}, mir[k]);
            end
            for (int k = 0; k < 21; k++) begin
                rd({1'b0, IDX[k]}, q);
                `CHK("stored byte", mir[k], q)
            end
        end
        `CHK("pointer word", {mir[1], mir[0]}, data_pointer_word)
        `CHK("flash address", {mir[18], mir[17]}, fadr)
        `CHK("flash data", mir[16], fwd)
        `CHK("boundaries", {mir[11], mir[9]}, {bndh, bndl})
        `CHK("aux and ien", {mir[5], mir[7]}, {aux, ien})
        `CHK("divider cmp", {mir[2], mir[8]}, {cdiv, cmpc})
        `CHK("conv ctl", {mir[3], mir[10]}, {cc1, mda})
        `CHK("conv mode", {mir[4], mir[6]}, {mdb, ins})
        $display("test random bytes done");
        for (int n = 0; n < 8; n++) begin
            d = 8'($random(seed));
            wr(9'h0e4, d);
            busy <= 1'($random(seed));
            flags <= 4'($random(seed));
            rd(9'h0e4, q);
            `CHK("flash status", {busy, 3'b111, flags}, q)
            `CHK("command byte", d, cmd)
            `CHK("command strobes", n + 1, stb_cnt)
        end
        $display("test flash control done");
        for (int r = 0; r < 2; r++) begin
            e = 8'($random(seed));
            wr(r ? 9'h0f0 : 9'h0e0, e);
            for (int b = 0; b < 8; b++) begin
                e[b] = 1'($random(seed));
                wr((r ? 9'h1f0 : 9'h1e0) + 9'(b), {7'h00, e[b]});
                rd((r ? 9'h1f0 : 9'h1e0) + 9'(b), q);
                `CHK("bit read", e[b], q[0])
            end
            rd(r ? 9'h0f0 : 9'h0e0, q);
            `CHK("byte after bits", e, q)
            `CHK("bit target port", e, r ? bq : accu)
        end
        $display("test bit access done");
        d = (8'($random(seed)) & 8'hf1) | 8'h08;
        wr(9'h0a2, d);
        rd(9'h0a2, q);
        `CHK("aux after soft reset", d & 8'hf1, q)
        `CHK("soft reset pulses", 1, swrst_cnt)
        sfrb_core_model_inst.xfer(1'b1, 9'h082, 4'he, ~mir[0], q);
        rd(9'h082, q);
        `CHK("write without lane", mir[0], q)
        rd(9'h1af, q);
        `CHK("enable bit read", mir[7][7], q[0])
        $display("test refused access done");
        busy <= 1'b0;
        flags <= 4'h0;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        chk_reset();
        conclude();
    end

    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        conclude();
    end
endmodule
